/* File: common/flash_pkg.sv */
// Shared constants for the serial flash status write and read logic
// Functional notes
// - Status write runs only when the write enable latch is already set.
// - Status write updates protect bits and disable bit, not latch or busy.
// - No status write executes while hardware protected mode is active.
// - Status write needs exactly eight data bits; otherwise nothing changes.
// - Timed status write cycle starts at the select rise ending the command.
// - Busy reads 1 during the cycle; at its end busy and latch clear.
// - With disable bit 0, status writes are accepted at any protect pin level.
// - With disable bit 1 and protect pin high, status writes are accepted.
// - With disable bit 1 and protect pin low, every status write is refused.
// - Hardware protection holds whenever disable bit is 1 and pin is low.
// - Hardware protection ends only when the protect pin goes high.
// - Protect level bits select the area shielded from program and erase; here they are only stored in the status byte, and no area is blocked.
// - Normal read samples address on rising edges, drives data on falling.
// - Read address increments after every byte and wraps to zero.
// - Normal read is opcode plus three address bytes, then streaming data.
// - Fast read adds one dummy byte before the data.
// - Fast and dual reads are refused while any write cycle runs.
// - Dual read is opcode, address, eight dummy clocks, data on two lines.
// - Dual read sends two bits per falling edge; command bits stay single.
// - Status byte: busy bit 0, latch bit 1, protect 2 to 5, disable bit 7.
// - Disable and protect bits reset to 0; busy and latch are volatile.
package flash_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int STATUS_WRITE_CYCLE_TIME_NS = 40000;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ    = 8'h3B;

  // ==========================================================================
  // Status byte layout and reset values
  localparam int BUSY_POS = 0;
  localparam int WEL_POS  = 1;
  localparam int BP_LSB   = 2;
  localparam int BP_MSB   = 5;
  localparam int RSVD_POS = 6;
  localparam int STATUS_WRITE_DISABLE_BIT_POS = 7;
  localparam logic [3:0] BP_RESET   = 4'h0;
  localparam logic       STATUS_WRITE_DISABLE_BIT_RESET = 1'b0;
  localparam logic       RSVD_VAL   = 1'b0;

  // ==========================================================================
  // Serial clock counts within a frame
  localparam logic [5:0] OP_LAST    = 6'h07;
  localparam logic [5:0] WRITE_ENABLE_CMD_OVER  = 6'h08;
  localparam logic [5:0] WSR_LAST   = 6'h0F;
  localparam logic [5:0] WSR_OVER   = 6'h10;
  localparam logic [5:0] ADDR_LAST  = 6'h1F;
  localparam logic [5:0] DUMMY_LAST = 6'h27;
  localparam logic [5:0] CNT_MAX    = 6'h3F;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [2:0] LAST_PAIR  = 3'h3;

  typedef enum logic [2:0] {
    ST_OP,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_WSR,
    ST_SKIP
  } frame_state_t;

endpackage

/* File: design/status_write_timer.sv */
// Self-timed status write cycle counter
module status_write_timer #(
  parameter int CYCLES = 10000,
  parameter int CNT_W  = $clog2(CYCLES + 1)
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Control
  input  wire logic i_start,
  // Status
  output logic      o_busy,
  output logic      o_done
);

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count;

  // ==========================================================================
  // Down counter
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count  <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        count  <= LOAD;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (count == '0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count <= count - CNT_W'(1);
        end
      end
    end
  end

endmodule

/* File: design/flash_cmd_core.sv */
// Serial flash status write, protection and read command logic
module flash_cmd_core #(
  parameter int TW_NS  = flash_pkg::STATUS_WRITE_CYCLE_TIME_NS,
  parameter int ADDR_W = 24
) (
  // System clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Serial link
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_d0,
  output logic                   o_d0,
  output logic                   o_d0_oe,
  output logic                   o_d1,
  output logic                   o_d1_oe,
  // Write protect pin
  input  wire logic              i_wp_n,
  // Memory array read port, serial clock domain
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [7:0]        i_rd_data,
  // Array program and erase activity, system clock domain
  input  wire logic              i_array_busy,
  // Status and protection
  output logic [7:0]             o_status,
  output logic                   o_hw_protected,
  output logic                   o_sw_protected
);

  localparam int TW_CYC = (TW_NS * flash_pkg::CLK_MHZ + 999) / 1000;
  localparam int TW_CYCLES = (TW_CYC < 1) ? 1 : TW_CYC;

  // ==========================================================================
  // Output bit select for single and dual data
  function automatic logic [2:0] hi_index(input logic [2:0] ix,
                                          input logic       dl);
    logic [2:0] r;
    r = dl ? (3'h7 - {ix[1:0], 1'b0}) : (3'h7 - ix);
    return r;
  endfunction

  // ==========================================================================
  // Entry state of a fast or dual read, refused while busy
  function automatic flash_pkg::frame_state_t gated_read(input logic bsy);
    flash_pkg::frame_state_t r;
    r = bsy ? flash_pkg::ST_SKIP : flash_pkg::ST_ADDR;
    return r;
  endfunction

  // ==========================================================================
  // Serial clock domain state
  logic                      frame_rst_n;
  flash_pkg::frame_state_t   state;
  logic [5:0]                cnt;
  logic [23:0]               shin;
  logic [7:0]                op;
  logic                      dual;
  logic                      has_dummy;
  logic [2:0]                dix;
  logic                      busy_s1;
  logic                      busy_s2;
  logic                      write_enable_cmd_ok;
  logic                      wsr_ok;
  logic [7:0]                wsr_byte;

  // ==========================================================================
  // System clock domain state
  logic                      cs_s1;
  logic                      cs_s2;
  logic                      cs_s3;
  logic                      wp_s1;
  logic                      wp_s2;
  logic                      write_enable_cmd_s1;
  logic                      write_enable_cmd_s2;
  logic                      wsr_s1;
  logic                      wsr_s2;
  logic [7:0]                byte_s1;
  logic [7:0]                byte_s2;
  logic                      cs_rise;
  logic                      write_enable_latch;
  logic                      status_write_disable_bit;
  logic [3:0]                bp;
  logic [7:0]                pend;
  logic                      hardware_protected_mode;
  logic                      busy_now;
  logic                      start;
  logic                      tmr_busy;
  logic                      tmr_done;

  assign frame_rst_n = i_nrst & ~i_cs_n;
  assign op          = {shin[6:0], i_d0};

  // ==========================================================================
  // Busy flag into the serial clock domain
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      busy_s1 <= o_status[flash_pkg::BUSY_POS];
      busy_s2 <= busy_s1;
    end
  end

  // ==========================================================================
  // Bit counter and input shift register, rising serial clock
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt  <= 6'h00;
      shin <= 24'h000000;
    end else begin
      if (cnt != flash_pkg::CNT_MAX) begin
        cnt <= cnt + 6'h01;
      end
      shin <= {shin[22:0], i_d0};
    end
  end

  // ==========================================================================
  // Frame decoder, rising serial clock
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state     <= flash_pkg::ST_OP;
      dual      <= 1'b0;
      has_dummy <= 1'b0;
      dix       <= 3'h0;
      o_rd_addr <= '0;
    end else begin
      case (state)
        flash_pkg::ST_OP: begin
          if (cnt == flash_pkg::OP_LAST) begin
            case (op)
              flash_pkg::OP_STATUS_WRITE: begin
                state <= flash_pkg::ST_WSR;
              end
              flash_pkg::OP_READ: begin
                state <= flash_pkg::ST_ADDR;
              end
              flash_pkg::OP_FAST_READ: begin
                has_dummy <= 1'b1;
                state     <= gated_read(busy_s2);
              end
              flash_pkg::OP_DUAL_READ: begin
                has_dummy <= 1'b1;
                dual      <= 1'b1;
                state     <= gated_read(busy_s2);
              end
              default: begin
                state <= flash_pkg::ST_SKIP;
              end
            endcase
          end
        end
        flash_pkg::ST_ADDR: begin
          if (cnt == flash_pkg::ADDR_LAST) begin
            o_rd_addr <= ADDR_W'({shin[22:0], i_d0});
            dix       <= 3'h0;
            state     <= has_dummy ? flash_pkg::ST_DUMMY
                                   : flash_pkg::ST_DATA;
          end
        end
        flash_pkg::ST_DUMMY: begin
          if (cnt == flash_pkg::DUMMY_LAST) begin
            state <= flash_pkg::ST_DATA;
          end
        end
        flash_pkg::ST_DATA: begin
          if (dix == (dual ? flash_pkg::LAST_PAIR : flash_pkg::LAST_BIT)) begin
            dix       <= 3'h0;
            o_rd_addr <= o_rd_addr + ADDR_W'(1);
          end else begin
            dix <= dix + 3'h1;
          end
        end
        flash_pkg::ST_WSR: begin
          state <= flash_pkg::ST_WSR;
        end
        flash_pkg::ST_SKIP: begin
          state <= flash_pkg::ST_SKIP;
        end
        default: begin
          state <= flash_pkg::ST_SKIP;
        end
      endcase
    end
  end

  // ==========================================================================
  // Completed command flags, held after select rises
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_enable_cmd_ok  <= 1'b0;
      wsr_ok   <= 1'b0;
      wsr_byte <= 8'h00;
    end else begin
      if (cnt == 6'h00) begin
        write_enable_cmd_ok <= 1'b0;
        wsr_ok  <= 1'b0;
      end else if (cnt == flash_pkg::OP_LAST) begin
        write_enable_cmd_ok <= (op == flash_pkg::OP_WRITE_ENABLE);
      end else if (cnt == flash_pkg::WRITE_ENABLE_CMD_OVER) begin
        write_enable_cmd_ok <= 1'b0;
      end
      if (state == flash_pkg::ST_WSR) begin
        if (cnt == flash_pkg::WSR_LAST) begin
          wsr_ok   <= 1'b1;
          wsr_byte <= op;
        end else if (cnt == flash_pkg::WSR_OVER) begin
          wsr_ok <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Output drivers, falling serial clock
  always_ff @(negedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      o_d1    <= 1'b0;
      o_d1_oe <= 1'b0;
      o_d0    <= 1'b0;
      o_d0_oe <= 1'b0;
    end else if (state == flash_pkg::ST_DATA) begin
      o_d1_oe <= 1'b1;
      o_d0_oe <= dual;
      o_d1    <= i_rd_data[hi_index(dix, dual)];
      o_d0    <= i_rd_data[hi_index(dix, dual) - 3'h1];
    end else begin
      o_d1_oe <= 1'b0;
      o_d0_oe <= 1'b0;
    end
  end

  // ==========================================================================
  // Select line into the system clock domain
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= i_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // ==========================================================================
  // Write protect pin synchroniser
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      wp_s1 <= i_wp_n;
      wp_s2 <= wp_s1;
    end
  end

  // ==========================================================================
  // Command flags and status byte, stable while select is high
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_enable_cmd_s1 <= 1'b0;
      write_enable_cmd_s2 <= 1'b0;
      wsr_s1  <= 1'b0;
      wsr_s2  <= 1'b0;
      byte_s1 <= 8'h00;
      byte_s2 <= 8'h00;
    end else begin
      write_enable_cmd_s1 <= write_enable_cmd_ok;
      write_enable_cmd_s2 <= write_enable_cmd_s1;
      wsr_s1  <= wsr_ok;
      wsr_s2  <= wsr_s1;
      byte_s1 <= wsr_byte;
      byte_s2 <= byte_s1;
    end
  end

  assign cs_rise  = cs_s2 & ~cs_s3;
  assign hardware_protected_mode      = status_write_disable_bit & ~wp_s2;
  assign busy_now = tmr_busy | i_array_busy;
  assign start    = cs_rise & wsr_s2 & write_enable_latch & ~hardware_protected_mode & ~busy_now;

  // ==========================================================================
  // Status write cycle timer
  status_write_timer #(
    .CYCLES (TW_CYCLES)
  ) u_timer (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_start (start),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  // ==========================================================================
  // Write enable latch
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_enable_latch <= 1'b0;
    end else if (cs_rise && write_enable_cmd_s2) begin
      write_enable_latch <= 1'b1;
    end else if (tmr_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ==========================================================================
  // Protect bits, committed at the end of the cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend <= 8'h00;
      status_write_disable_bit <= flash_pkg::STATUS_WRITE_DISABLE_BIT_RESET;
      bp   <= flash_pkg::BP_RESET;
    end else begin
      if (start) begin
        pend <= byte_s2;
      end
      if (tmr_done) begin
        status_write_disable_bit <= pend[flash_pkg::STATUS_WRITE_DISABLE_BIT_POS];
        bp   <= pend[flash_pkg::BP_MSB:flash_pkg::BP_LSB];
      end
    end
  end

  // ==========================================================================
  // Status and protection outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status       <= 8'h00;
      o_hw_protected <= 1'b0;
      o_sw_protected <= 1'b1;
    end else begin
      o_status[flash_pkg::BUSY_POS]                <= busy_now;
      o_status[flash_pkg::WEL_POS]                 <= write_enable_latch;
      o_status[flash_pkg::BP_MSB:flash_pkg::BP_LSB] <= bp;
      o_status[flash_pkg::RSVD_POS]                <= flash_pkg::RSVD_VAL;
      o_status[flash_pkg::STATUS_WRITE_DISABLE_BIT_POS]                <= status_write_disable_bit;
      o_hw_protected <= hardware_protected_mode;
      o_sw_protected <= ~hardware_protected_mode;
    end
  end

endmodule

/* File: verif/flash_cmd_monitor.sv */
// Assertion checker for the flash command core
module flash_cmd_monitor (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_nrst,
  // Pins
  input wire logic       i_cs_n,
  input wire logic       i_wp_n,
  input wire logic       i_array_busy,
  input wire logic       o_d0_oe,
  input wire logic       o_d1_oe,
  // Status
  input wire logic [7:0] o_status,
  input wire logic       o_hw_protected
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_oe_released: assert property (
    i_cs_n |-> !o_d0_oe && !o_d1_oe) else $error("drive with select high");
  a_dual_pair: assert property (
    o_d0_oe |-> o_d1_oe) else $error("line zero driven alone");
  a_rsvd_zero: assert property (
    o_status[6] == 1'b0) else $error("reserved bit set");
  a_hw_enter: assert property (
    (o_status[7] && !i_wp_n) [*5] |-> o_hw_protected)
    else $error("hardware mode not entered");
  a_hw_leave: assert property (
    i_wp_n [*5] |-> !o_hw_protected) else $error("hardware mode kept");
  a_busy_len: assert property (
    $rose(o_status[0]) && !i_array_busy |-> o_status[0] [*8])
    else $error("busy too short");
  a_wel_clear: assert property (
    $fell(o_status[0]) && !$past(i_array_busy, 4) |-> ##[0:2] !o_status[1])
    else $error("latch not cleared");
  a_bits_at_end: assert property (
    $changed(o_status[7:2]) |-> $past(o_status[0]) || $past(o_status[0], 2))
    else $error("protect bits changed outside cycle end");
  a_busy_array: assert property (
    $rose(i_array_busy) |-> ##[1:3] o_status[0])
    else $error("array activity not in busy");
endmodule

bind flash_cmd_core flash_cmd_monitor flash_cmd_monitor_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .i_wp_n(i_wp_n),
  .i_array_busy(i_array_busy), .o_d0_oe(o_d0_oe), .o_d1_oe(o_d1_oe),
  .o_status(o_status), .o_hw_protected(o_hw_protected));

/* File: verif/flash_host_model.sv */
// Host controller model driving the serial flash link
module flash_host_model (
  // Link out
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_d0,
  // Link in
  input wire logic  i_d0,
  input wire logic  i_d1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_d0 = 1'b1;
  end
  // ====
  // One frame, clock stopped outside it
  task automatic xfer(input logic [39:0] tx, input int n_tx, input int n_rx,
                      input bit dual, output logic [15:0] rx);
    rx = 16'h0000;
    #101.3 o_cs_n = 1'b0;
    for (int i = 0; i < n_tx + n_rx; i++) begin
      o_d0 = (i < n_tx) ? tx[39-i] : ~o_d0;
      #20 o_sclk = 1'b1;
      if (i >= n_tx) begin
        rx = dual ? {rx[13:0], i_d1, i_d0} : {rx[14:0], i_d1};
      end
      #40 o_sclk = 1'b0;
      #20;
    end
    o_cs_n = 1'b1;
  endtask
endmodule

/* File: verif/tb.sv */
// Self-checking testbench for the flash command core
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, sclk, cs_n, d0_in, d0_out, d0_oe, d1, d1_oe;
  logic        wp_n, array_busy, hw_prot, sw_prot, oe_seen;
  logic [7:0]  rd_addr, rd_data, status;
  logic [15:0] rx;
  int          n_fail, checks_done;

  flash_cmd_core #(.TW_NS(40), .ADDR_W(8)) flash_cmd_core_inst (
    .i_clk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_d0(d0_in), .o_d0(d0_out), .o_d0_oe(d0_oe), .o_d1(d1),
    .o_d1_oe(d1_oe), .i_wp_n(wp_n), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .i_array_busy(array_busy), .o_status(status),
    .o_hw_protected(hw_prot), .o_sw_protected(sw_prot));
  // Pull-ups on released data lines
  wire         d0_line = d0_oe ? d0_out : 1'b1;
  wire         d1_line = d1_oe ? d1 : 1'b1;
  flash_host_model host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_d0(d0_in),
    .i_d0(d0_line), .i_d1(d1_line));

  function automatic logic [7:0] pat(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'hA5;
  endfunction
  assign rd_data = pat(rd_addr);
  always #2 clk = ~clk;
  always @(posedge d1_oe) oe_seen = 1'b1;

  // ====
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] b, input int n);
    host_inst.xfer({op, b, 24'h000000}, n, 0, 1'b0, rx);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic set_wp(input logic v);
    @(posedge clk);
    #1 wp_n = v;
    settle(10);
  endtask
  task automatic wsr(input logic [7:0] b, input logic run);
    int k;
    cmd(flash_pkg::OP_WRITE_ENABLE, 8'h00, 8);
    cmd(flash_pkg::OP_STATUS_WRITE, b, 16);
    k = 0;
    while (status[0] !== 1'b1 && k < 20) begin
      settle(1);
      k++;
    end
    check("busy start", {15'h0000, status[0]}, {15'h0000, run});
    settle(30);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] a,
                    input int n_tx, input bit dual, input string what);
    host_inst.xfer({op, 16'h0000, a, 8'h00}, n_tx, dual ? 8 : 16, dual, rx);
    check(what, rx, {pat(a), pat(a + 8'h01)});
    #1 check("oe idle", {14'h0000, d0_oe, d1_oe}, 16'h0000);
  endtask

  // ====
  // Scenarios
  task automatic t_reset;
    check("status", {8'h00, status}, 16'h0000);
    check("modes", {14'h0000, hw_prot, sw_prot}, 16'h0001);
    $display("test reset done");
  endtask
  task automatic t_soft;
    cmd(flash_pkg::OP_STATUS_WRITE, 8'h3C, 16);
    settle(30);
    check("no latch", {8'h00, status}, 16'h0000);
    set_wp(1'b0);
    wsr(8'h3C, 1'b1);
    check("wp low", {8'h00, status}, 16'h003C);
    set_wp(1'b1);
    wsr(8'hFF, 1'b1);
    check("wp high", {8'h00, status}, 16'h00BC);
    $display("test soft done");
  endtask
  task automatic t_hard;
    set_wp(1'b0);
    check("hw on", {14'h0000, hw_prot, sw_prot}, 16'h0002);
    wsr(8'h00, 1'b0);
    check("refused", {8'h00, status}, 16'h00BE);
    set_wp(1'b1);
    check("hw off", {14'h0000, hw_prot, sw_prot}, 16'h0001);
    cmd(flash_pkg::OP_STATUS_WRITE, 8'h00, 16);
    settle(40);
    check("cleared", {8'h00, status}, 16'h0000);
    $display("test hard done");
  endtask
  task automatic t_count;
    cmd(flash_pkg::OP_WRITE_ENABLE, 8'h00, 8);
    for (int n = 15; n <= 17; n += 2) begin
      cmd(flash_pkg::OP_STATUS_WRITE, 8'h3C, n);
      settle(30);
      check("bit count", {8'h00, status}, 16'h0002);
    end
    $display("test count done");
  endtask
  task automatic t_read;
    rd(flash_pkg::OP_READ, 8'hFF, 32, 1'b0, "read");
    rd(flash_pkg::OP_FAST_READ, 8'h10, 40, 1'b0, "fast");
    rd(flash_pkg::OP_DUAL_READ, 8'h7F, 40, 1'b1, "dual");
    $display("test read done");
  endtask
  task automatic t_busy;
    @(posedge clk);
    #1 array_busy = 1'b1;
    settle(5);
    check("busy", {15'h0000, status[0]}, 16'h0001);
    oe_seen = 1'b0;
    host_inst.xfer({flash_pkg::OP_FAST_READ, 32'h0}, 40, 16, 1'b0, rx);
    host_inst.xfer({flash_pkg::OP_DUAL_READ, 32'h0}, 40, 8, 1'b1, rx);
    check("refused drive", {15'h0000, oe_seen}, 16'h0000);
    rd(flash_pkg::OP_READ, 8'h42, 32, 1'b0, "busy read");
    @(posedge clk);
    #1 array_busy = 1'b0;
    settle(10);
    $display("test busy done");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wp_n = 1'b1;
    array_busy = 1'b0;
    oe_seen = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    settle(5);
    t_reset;
    t_soft;
    t_hard;
    t_count;
    t_read;
    t_busy;
    end_sim;
  end
  initial begin
    #300000;
    n_fail++;
    $display("watchdog expired");
    end_sim;
  end
endmodule
